// file: rtl/eis_map.svh
`ifndef EIS_MAP_SVH
`define EIS_MAP_SVH

// ----------------------------------------
// Timing, in nanoseconds and clock cycles
// ----------------------------------------
`define EIS_CLK_PERIOD_NS 25
`define EIS_ENA_DET_NS 40000
`define EIS_ENA_FILT_NS 20000
// Least time: round up
`define EIS_ENA_DET_CYC ((`EIS_ENA_DET_NS + `EIS_CLK_PERIOD_NS - 1) / `EIS_CLK_PERIOD_NS)
`define EIS_BUCK_RISE_NS 320000
`define EIS_BOOST_RISE_NS 640000
`define EIS_BUCK_RISE_CYC (`EIS_BUCK_RISE_NS / `EIS_CLK_PERIOD_NS)
`define EIS_BOOST_RISE_CYC (`EIS_BOOST_RISE_NS / `EIS_CLK_PERIOD_NS)
`define EIS_STG_CYC 32000

// ----------------------------------------
// Configuration reset values
// ----------------------------------------
`define EIS_TRIG_SEL_RST 1'b0

`endif

// file: rtl/eis_pkg.sv
package eis_pkg;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_STG1 = 3'b001,
        SEQ_STG2 = 3'b010,
        SEQ_STG3 = 3'b011,
        SEQ_DONE = 3'b100,
        SEQ_FAIL = 3'b101
    } eis_seq_e;

    typedef enum logic [1:0] {
        SYS_DISABLED = 2'b00,
        SYS_ACTIVE = 2'b01,
        SYS_FAULT = 2'b10,
        SYS_LOCKED = 2'b11
    } eis_sys_e;

endpackage : eis_pkg

// file: rtl/eis_deglitch.sv
`timescale 1ns/1ps
`default_nettype none

module eis_deglitch #(
    parameter int DET_CYC = 1600
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Raw and filtered level
    input wire logic raw_in,
    output logic level_q,
    output logic rise_q,
    output logic fall_q
);

    localparam int CW = $clog2(DET_CYC + 1);

    logic [CW-1:0] cnt_q;
    logic raw_q;

    // ----------------------------------------
    // Duration counter
    // ----------------------------------------
    // Restarts on every raw change, so any pulse shorter than the
    // detection time is dropped, which covers the filter time too
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            raw_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            raw_q <= raw_in;
            if (raw_in != raw_q) begin
                cnt_q <= '0;
            end else if (cnt_q != CW'(DET_CYC)) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            // Same qualification for high and low
            if (cnt_q == CW'(DET_CYC - 1) && raw_q == raw_in && raw_q != level_q) begin
                level_q <= raw_q;
                rise_q <= raw_q;
                fall_q <= ~raw_q;
            end
        end
    end

endmodule : eis_deglitch

`default_nettype wire

// file: rtl/eis_rail_timer.sv
`timescale 1ns/1ps
`default_nettype none

module eis_rail_timer #(
    parameter int RISE_CYC = 12800,
    parameter int STG_CYC = 32000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Rail control
    input wire logic run,
    input wire logic used,
    input wire logic uv_ok,
    input wire logic ov_ok,
    // Results
    output logic ready,
    output logic timeout,
    output logic uv_armed
);

    localparam int MAXC = (RISE_CYC > STG_CYC) ? RISE_CYC : STG_CYC;
    localparam int CW = $clog2(MAXC + 1);

    logic [CW-1:0] cnt_q;
    logic rise_done;
    logic in_band;

    assign rise_done = (cnt_q >= CW'(RISE_CYC));
    assign in_band = uv_ok && ov_ok;
    // Unused rail is skipped at once
    assign ready = run && (!used || (in_band && rise_done));
    assign timeout = run && used && !in_band && (cnt_q >= CW'(STG_CYC));

    always_ff @(posedge clk_sys) begin
        if (srst || !run) begin
            cnt_q <= '0;
        end else if (cnt_q != CW'(MAXC)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Undervoltage reporting only after first crossing
    always_ff @(posedge clk_sys) begin
        if (srst || !run || !used) begin
            uv_armed <= 1'b0;
        end else if (uv_ok) begin
            uv_armed <= 1'b1;
        end
    end

endmodule : eis_rail_timer

`default_nettype wire

// file: rtl/eis_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "eis_map.svh"

module eis_sequencer #(
    parameter int DET_CYC = `EIS_ENA_DET_CYC,
    parameter int BUCK_RISE_CYC = `EIS_BUCK_RISE_CYC,
    parameter int BOOST_RISE_CYC = `EIS_BOOST_RISE_CYC,
    parameter int STG_CYC = `EIS_STG_CYC,
    parameter int FAULT_LIMIT = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Wake enable pin
    input wire logic wake_enable_input,
    // Configuration from host
    input wire logic cfg_wr,
    input wire logic cfg_trigger_level,
    input wire logic ctrl_disable_wr,
    input wire logic ctrl_enable_wr,
    input wire logic event_flag_clr,
    input wire logic stg_fault_to_state,
    // Fault input from monitors
    input wire logic sys_fault_in,
    // Rail feedback
    input wire logic primary_buck_uv_ok,
    input wire logic primary_buck_ov_ok,
    input wire logic secondary_buck_uv_ok,
    input wire logic secondary_buck_ov_ok,
    input wire logic boost_uv_ok,
    input wire logic boost_ov_ok,
    input wire logic mon_one_uv_ok,
    input wire logic mon_one_ov_ok,
    input wire logic mon_two_uv_ok,
    input wire logic mon_two_ov_ok,
    // Use detection readback from enable pins
    input wire logic mon_one_en_in,
    input wire logic mon_two_en_in,
    // Status
    output logic enable_level_status_bit,
    output logic enable_event_flag,
    output logic enable_trigger_select,
    output logic monitor_one_present_bit,
    output logic monitor_two_present_bit,
    output logic [1:0] sys_state,
    output logic stg_fault_flag,
    output logic seq_done,
    // Rail enables
    output logic primary_buck_en,
    output logic secondary_buck_en,
    output logic boost_en,
    output logic mon_one_en,
    output logic mon_two_en,
    // Monitor arming
    output logic [4:0] uv_report_en,
    output logic [4:0] ov_mon_en
);

    // ----------------------------------------
    // Enable input filter
    // ----------------------------------------
    logic ena_level;
    logic ena_rise;
    logic ena_fall;

    eis_deglitch #(
        .DET_CYC(DET_CYC)
    ) u_deglitch (
        .clk_sys(clk_sys),
        .srst(srst),
        .raw_in(wake_enable_input),
        .level_q(ena_level),
        .rise_q(ena_rise),
        .fall_q(ena_fall)
    );

    assign enable_level_status_bit = ena_level;

    // Set wins over clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            enable_event_flag <= 1'b0;
        end else if (ena_rise || ena_fall) begin
            enable_event_flag <= 1'b1;
        end else if (event_flag_clr) begin
            enable_event_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Configuration bit
    // ----------------------------------------
    eis_pkg::eis_sys_e state_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            enable_trigger_select <= `EIS_TRIG_SEL_RST;
        end else if (ctrl_disable_wr && state_q != eis_pkg::SYS_DISABLED) begin
            enable_trigger_select <= `EIS_TRIG_SEL_RST;
        end else if (cfg_wr) begin
            enable_trigger_select <= cfg_trigger_level;
        end
    end

    // ----------------------------------------
    // System state
    // ----------------------------------------
    logic [1:0] fault_cnt_q;
    logic wake;
    logic stg_timeout;
    logic lvl_hold;

    // Edge mode wakes only on rising edge
    assign wake = enable_trigger_select ? ena_level : ena_rise;
    assign lvl_hold = enable_trigger_select && ena_level;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= eis_pkg::SYS_DISABLED;
            fault_cnt_q <= 2'h0;
        end else begin
            case (state_q)
                eis_pkg::SYS_DISABLED: begin
                    if (wake || ctrl_enable_wr) begin
                        state_q <= eis_pkg::SYS_ACTIVE;
                    end
                end
                eis_pkg::SYS_ACTIVE: begin
                    // Events alone never lead here to DISABLED
                    if (ctrl_disable_wr) begin
                        state_q <= eis_pkg::SYS_DISABLED;
                    end else if (sys_fault_in || (stg_timeout && stg_fault_to_state)) begin
                        state_q <= eis_pkg::SYS_FAULT;
                    end else if (seq_done) begin
                        fault_cnt_q <= 2'h0;
                    end
                end
                eis_pkg::SYS_FAULT: begin
                    if (lvl_hold) begin
                        state_q <= eis_pkg::SYS_ACTIVE;
                    end else if (32'(fault_cnt_q) + 1 >= FAULT_LIMIT) begin
                        state_q <= eis_pkg::SYS_LOCKED;
                    end else if (!sys_fault_in) begin
                        fault_cnt_q <= fault_cnt_q + 2'h1;
                        state_q <= eis_pkg::SYS_ACTIVE;
                    end
                end
                eis_pkg::SYS_LOCKED: begin
                    if (ctrl_disable_wr) begin
                        state_q <= eis_pkg::SYS_DISABLED;
                    end
                end
                default: state_q <= eis_pkg::SYS_DISABLED;
            endcase
        end
    end

    assign sys_state = state_q;

    // ----------------------------------------
    // Use detection, sampled every cycle while DISABLED and held after leaving
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            monitor_one_present_bit <= 1'b0;
            monitor_two_present_bit <= 1'b0;
        end else if (state_q == eis_pkg::SYS_DISABLED) begin
            monitor_one_present_bit <= mon_one_en_in;
            monitor_two_present_bit <= mon_two_en_in;
        end
    end

    // ----------------------------------------
    // Rail sequencing
    // ----------------------------------------
    eis_pkg::eis_seq_e seq_q;
    logic [4:0] run;
    logic [4:0] used;
    logic [4:0] uvo;
    logic [4:0] ovo;
    logic [4:0] rdy;
    logic [4:0] tmo;
    logic [4:0] arm;

    assign used = {monitor_two_present_bit, monitor_one_present_bit, 3'b111};
    assign uvo = {mon_two_uv_ok, mon_one_uv_ok, boost_uv_ok, secondary_buck_uv_ok,
                  primary_buck_uv_ok};
    assign ovo = {mon_two_ov_ok, mon_one_ov_ok, boost_ov_ok, secondary_buck_ov_ok,
                  primary_buck_ov_ok};
    assign run = {{2{seq_q == eis_pkg::SEQ_STG3 || seq_q == eis_pkg::SEQ_DONE}},
                  {2{seq_q >= eis_pkg::SEQ_STG2 && seq_q != eis_pkg::SEQ_FAIL}},
                  seq_q != eis_pkg::SEQ_IDLE && seq_q != eis_pkg::SEQ_FAIL};

    eis_rail_timer #(.RISE_CYC(BUCK_RISE_CYC), .STG_CYC(STG_CYC)) u_rail0 (
        .clk_sys(clk_sys), .srst(srst), .run(run[0]), .used(used[0]), .uv_ok(uvo[0]),
        .ov_ok(ovo[0]), .ready(rdy[0]), .timeout(tmo[0]), .uv_armed(arm[0]));
    eis_rail_timer #(.RISE_CYC(BUCK_RISE_CYC), .STG_CYC(STG_CYC)) u_rail1 (
        .clk_sys(clk_sys), .srst(srst), .run(run[1]), .used(used[1]), .uv_ok(uvo[1]),
        .ov_ok(ovo[1]), .ready(rdy[1]), .timeout(tmo[1]), .uv_armed(arm[1]));
    eis_rail_timer #(.RISE_CYC(BOOST_RISE_CYC), .STG_CYC(STG_CYC)) u_rail2 (
        .clk_sys(clk_sys), .srst(srst), .run(run[2]), .used(used[2]), .uv_ok(uvo[2]),
        .ov_ok(ovo[2]), .ready(rdy[2]), .timeout(tmo[2]), .uv_armed(arm[2]));
    eis_rail_timer #(.RISE_CYC(1), .STG_CYC(STG_CYC)) u_rail3 (
        .clk_sys(clk_sys), .srst(srst), .run(run[3]), .used(used[3]), .uv_ok(uvo[3]),
        .ov_ok(ovo[3]), .ready(rdy[3]), .timeout(tmo[3]), .uv_armed(arm[3]));
    eis_rail_timer #(.RISE_CYC(1), .STG_CYC(STG_CYC)) u_rail4 (
        .clk_sys(clk_sys), .srst(srst), .run(run[4]), .used(used[4]), .uv_ok(uvo[4]),
        .ov_ok(ovo[4]), .ready(rdy[4]), .timeout(tmo[4]), .uv_armed(arm[4]));

    assign stg_timeout = |tmo;

    always_ff @(posedge clk_sys) begin
        if (srst || state_q != eis_pkg::SYS_ACTIVE) begin
            seq_q <= eis_pkg::SEQ_IDLE;
        end else begin
            case (seq_q)
                eis_pkg::SEQ_IDLE: seq_q <= eis_pkg::SEQ_STG1;
                eis_pkg::SEQ_STG1: begin
                    if (rdy[0]) begin
                        seq_q <= eis_pkg::SEQ_STG2;
                    end
                end
                eis_pkg::SEQ_STG2: begin
                    if (rdy[1] && rdy[2]) begin
                        seq_q <= eis_pkg::SEQ_STG3;
                    end
                end
                eis_pkg::SEQ_STG3: begin
                    if (rdy[3] && rdy[4]) begin
                        seq_q <= eis_pkg::SEQ_DONE;
                    end
                end
                eis_pkg::SEQ_DONE: seq_q <= eis_pkg::SEQ_DONE;
                eis_pkg::SEQ_FAIL: seq_q <= eis_pkg::SEQ_FAIL;
                default: seq_q <= eis_pkg::SEQ_IDLE;
            endcase
        end
    end

    // Timeout flag is sticky until the next power-up
    // Either kind of power-up clears it, pin wake or host enable
    always_ff @(posedge clk_sys) begin
        if (srst || (state_q == eis_pkg::SYS_DISABLED && (wake || ctrl_enable_wr))) begin
            stg_fault_flag <= 1'b0;
        end else if (stg_timeout) begin
            stg_fault_flag <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            primary_buck_en <= 1'b0;
            secondary_buck_en <= 1'b0;
            boost_en <= 1'b0;
            mon_one_en <= 1'b0;
            mon_two_en <= 1'b0;
            uv_report_en <= 5'h00;
            ov_mon_en <= 5'h00;
            seq_done <= 1'b0;
        end else begin
            primary_buck_en <= run[0];
            secondary_buck_en <= run[1];
            boost_en <= run[2];
            mon_one_en <= run[3] && used[3];
            mon_two_en <= run[4] && used[4];
            uv_report_en <= arm & run;
            ov_mon_en <= run & used;
            seq_done <= (seq_q == eis_pkg::SEQ_DONE);
        end
    end

endmodule : eis_sequencer

`default_nettype wire

// file: dv/eis_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none

module eis_sequencer_sva #(
    parameter int DET_CYC = 8,
    parameter int BUCK_RISE_CYC = 20,
    parameter int BOOST_RISE_CYC = 40
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Watched inputs
    input wire logic wake_enable_input,
    input wire logic cfg_wr,
    input wire logic cfg_trigger_level,
    input wire logic ctrl_disable_wr,
    input wire logic event_flag_clr,
    // Watched outputs
    input wire logic enable_level_status_bit,
    input wire logic enable_event_flag,
    input wire logic enable_trigger_select,
    input wire logic monitor_one_present_bit,
    input wire logic [1:0] sys_state,
    input wire logic primary_buck_en,
    input wire logic secondary_buck_en,
    input wire logic boost_en,
    input wire logic mon_one_en,
    input wire logic [4:0] ov_mon_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic raw_q;
    int stab_q;
    int buck_q;
    int boost_q;
    // Saturate so a long quiet pin never wraps
    always_ff @(posedge clk_sys) begin
        raw_q <= wake_enable_input;
        if (srst || wake_enable_input != raw_q) stab_q <= 0;
        else if (stab_q < 1000) stab_q <= stab_q + 1;
    end
    always_ff @(posedge clk_sys) begin
        buck_q <= primary_buck_en ? ((buck_q < 1000) ? buck_q + 1 : buck_q) : 0;
        boost_q <= boost_en ? ((boost_q < 1000) ? boost_q + 1 : boost_q) : 0;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_level_edge;
        $changed(enable_level_status_bit);
    endsequence

    AST_LEVEL_QUALIFIED: assert property (s_level_edge |-> stab_q >= DET_CYC - 1)
        else $error("filtered level changed before the pin was stable");
    AST_EVENT_ON_EDGE: assert property (s_level_edge |=> enable_event_flag)
        else $error("no event flag after a filtered edge");
    AST_FLAG_HELD: assert property (enable_event_flag && !event_flag_clr |=> enable_event_flag)
        else $error("event flag dropped without a clear");
    AST_TRIG_WRITE: assert property (cfg_wr && !ctrl_disable_wr
        |=> enable_trigger_select == $past(cfg_trigger_level))
        else $error("trigger select not loaded");
    AST_TRIG_DEFAULT: assert property (ctrl_disable_wr && !cfg_wr
        && sys_state == eis_pkg::SYS_ACTIVE |=> !enable_trigger_select)
        else $error("trigger select kept after disable");
    AST_NO_SELF_DISABLE: assert property (sys_state == eis_pkg::SYS_ACTIVE && !ctrl_disable_wr
        |=> sys_state != eis_pkg::SYS_DISABLED)
        else $error("device disabled itself");
    AST_NO_LOCK_LEVEL: assert property (sys_state == eis_pkg::SYS_FAULT && enable_trigger_select
        && enable_level_status_bit |=> sys_state != eis_pkg::SYS_LOCKED)
        else $error("locked while level mode and pin high");
    AST_STG2_RISE: assert property ($rose(secondary_buck_en) |-> buck_q >= BUCK_RISE_CYC - 2)
        else $error("second stage before primary rise time");
    AST_STG3_RISE: assert property ($rose(mon_one_en)
        |-> boost_q >= BOOST_RISE_CYC - 2 && secondary_buck_en)
        else $error("third stage before boost rise time");
    AST_SKIP_UNUSED: assert property (sys_state == eis_pkg::SYS_ACTIVE && $stable(sys_state)
        && !monitor_one_present_bit |-> !mon_one_en)
        else $error("unused monitor enabled");
    AST_OV_ARMED: assert property ($rose(primary_buck_en) |-> ##[0:1] ov_mon_en[0])
        else $error("overvoltage monitor not armed");
endmodule : eis_sequencer_sva

bind eis_sequencer eis_sequencer_sva #(.DET_CYC(DET_CYC), .BUCK_RISE_CYC(BUCK_RISE_CYC),
    .BOOST_RISE_CYC(BOOST_RISE_CYC)) eis_sequencer_sva_inst (.*);

`default_nettype wire

// file: dv/eis_rail_model.sv
`timescale 1ns/1ps
`default_nettype none

module eis_rail_model #(
    parameter int RISE = 5
) (
    // Clock
    input wire logic clk_sys,
    // Rail enables, bit0 primary
    input wire logic [4:0] en,
    input wire logic short_primary,
    // Window comparators
    output logic [4:0] uv_ok,
    output logic [4:0] ov_ok
);
    int cnt [5];
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 5; i++) begin
            cnt[i] <= en[i] ? ((cnt[i] < RISE) ? cnt[i] + 1 : cnt[i]) : 0;
        end
    end
    // A shorted rail never reaches its band
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            uv_ok[i] = en[i] && cnt[i] >= RISE && !(i == 0 && short_primary);
        end
    end
    assign ov_ok = 5'h1f;
endmodule : eis_rail_model

`default_nettype wire

// file: dv/test_enable_input_and_rail_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "eis_map.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module test_enable_input_and_rail_sequencer;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic wake_enable_input = 1'b0;
    logic cfg_wr = 1'b0, cfg_trigger_level = 1'b0, ctrl_disable_wr = 1'b0;
    logic event_flag_clr = 1'b0, stg_fault_to_state = 1'b0, sys_fault_in = 1'b0;
    logic ctrl_enable_wr = 1'b0;
    logic mon_one_en_in = 1'b1, mon_two_en_in = 1'b1, short_primary = 1'b0;
    logic enable_level_status_bit, enable_event_flag, enable_trigger_select;
    logic monitor_one_present_bit, monitor_two_present_bit, stg_fault_flag, seq_done;
    logic primary_buck_en, secondary_buck_en, boost_en, mon_one_en, mon_two_en;
    logic [1:0] sys_state;
    logic [4:0] uv_report_en, ov_mon_en, uv_ok, ov_ok, rails;
    int n_fail = 0;
    int n_checks = 0;

    assign rails = {mon_two_en, mon_one_en, boost_en, secondary_buck_en, primary_buck_en};

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Short counts keep the run brief
    eis_sequencer #(.DET_CYC(8), .BUCK_RISE_CYC(20), .BOOST_RISE_CYC(40), .STG_CYC(50))
    eis_sequencer_inst (
        .clk_sys(clk_sys), .srst(srst), .wake_enable_input(wake_enable_input),
        .cfg_wr(cfg_wr), .cfg_trigger_level(cfg_trigger_level),
        .ctrl_disable_wr(ctrl_disable_wr), .ctrl_enable_wr(ctrl_enable_wr),
        .event_flag_clr(event_flag_clr), .stg_fault_to_state(stg_fault_to_state),
        .sys_fault_in(sys_fault_in),
        .primary_buck_uv_ok(uv_ok[0]), .primary_buck_ov_ok(ov_ok[0]),
        .secondary_buck_uv_ok(uv_ok[1]), .secondary_buck_ov_ok(ov_ok[1]),
        .boost_uv_ok(uv_ok[2]), .boost_ov_ok(ov_ok[2]),
        .mon_one_uv_ok(uv_ok[3]), .mon_one_ov_ok(ov_ok[3]),
        .mon_two_uv_ok(uv_ok[4]), .mon_two_ov_ok(ov_ok[4]),
        .mon_one_en_in(mon_one_en_in), .mon_two_en_in(mon_two_en_in),
        .enable_level_status_bit(enable_level_status_bit),
        .enable_event_flag(enable_event_flag), .enable_trigger_select(enable_trigger_select),
        .monitor_one_present_bit(monitor_one_present_bit),
        .monitor_two_present_bit(monitor_two_present_bit), .sys_state(sys_state),
        .stg_fault_flag(stg_fault_flag), .seq_done(seq_done),
        .primary_buck_en(primary_buck_en), .secondary_buck_en(secondary_buck_en),
        .boost_en(boost_en), .mon_one_en(mon_one_en), .mon_two_en(mon_two_en),
        .uv_report_en(uv_report_en), .ov_mon_en(ov_mon_en)
    );

    eis_rail_model #(.RISE(5)) eis_rail_model_inst (
        .clk_sys(clk_sys), .en(rails), .short_primary(short_primary),
        .uv_ok(uv_ok), .ov_ok(ov_ok)
    );

    // ----------------------------------------
    // Host access tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    // op 0 config write, 1 disable, 2 clear event flag, 3 enable
    task automatic host_write(input int op, input logic lvl);
        cfg_trigger_level = lvl;
        cfg_wr = (op == 0);
        ctrl_disable_wr = (op == 1);
        event_flag_clr = (op == 2);
        ctrl_enable_wr = (op == 3);
        tick(1);
        {cfg_wr, ctrl_disable_wr, event_flag_clr, ctrl_enable_wr} = 4'h0;
        tick(1);
    endtask : host_write

    task automatic set_pin(input logic v, input int n);
        wake_enable_input = v;
        tick(n);
    endtask : set_pin

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        tick(6);
        srst = 1'b0;
        tick(1);
        `CHK(sys_state, eis_pkg::SYS_DISABLED)
        `CHK(enable_trigger_select, `EIS_TRIG_SEL_RST)
        set_pin(1'b1, 4);
        set_pin(1'b0, 20);
        `CHK(enable_level_status_bit, 1'b0)
        `CHK(enable_event_flag, 1'b0)
        set_pin(1'b1, 20);
        `CHK(enable_level_status_bit, 1'b1)
        `CHK(enable_event_flag, 1'b1)
        for (int i = 0; i < 400 && seq_done !== 1'b1; i++) tick(1);
        `CHK(sys_state, eis_pkg::SYS_ACTIVE)
        `CHK(rails, 5'h1f)
        `CHK(ov_mon_en, 5'h1f)
        `CHK(uv_report_en, 5'h1f)
        `CHK({monitor_two_present_bit, monitor_one_present_bit}, 2'h3)
        host_write(2, 1'b0);
        `CHK(enable_event_flag, 1'b0)
        host_write(0, 1'b1);
        `CHK(enable_trigger_select, 1'b1)
        // Three faults in a row would lock in edge mode
        for (int k = 0; k < 3; k++) begin
            sys_fault_in = 1'b1;
            tick(3);
            sys_fault_in = 1'b0;
            for (int i = 0; i < 400 && sys_state !== eis_pkg::SYS_ACTIVE; i++) tick(1);
            tick(2);
        end
        `CHK(sys_state, eis_pkg::SYS_ACTIVE)
        set_pin(1'b0, 20);
        `CHK(enable_level_status_bit, 1'b0)
        `CHK(enable_event_flag, 1'b1)
        `CHK(sys_state, eis_pkg::SYS_ACTIVE)
        host_write(1, 1'b0);
        `CHK(sys_state, eis_pkg::SYS_DISABLED)
        `CHK(enable_trigger_select, 1'b0)
        mon_one_en_in = 1'b0;
        mon_two_en_in = 1'b0;
        tick(2);
        `CHK({monitor_two_present_bit, monitor_one_present_bit}, 2'h0)
        set_pin(1'b1, 20);
        for (int i = 0; i < 400 && seq_done !== 1'b1; i++) tick(1);
        `CHK(rails, 5'h07)
        host_write(1, 1'b0);
        short_primary = 1'b1;
        stg_fault_to_state = 1'b1;
        set_pin(1'b0, 20);
        set_pin(1'b1, 1);
        for (int i = 0; i < 400 && stg_fault_flag !== 1'b1; i++) tick(1);
        `CHK(stg_fault_flag, 1'b1)
        `CHK(secondary_buck_en, 1'b0)
        `CHK(uv_report_en[0], 1'b0)
        `CHK(sys_state, eis_pkg::SYS_FAULT)
        // Edge mode: each retry times out again, third fault locks
        for (int i = 0; i < 400 && sys_state !== eis_pkg::SYS_LOCKED; i++) tick(1);
        `CHK(sys_state, eis_pkg::SYS_LOCKED)
        host_write(1, 1'b0);
        `CHK(sys_state, eis_pkg::SYS_DISABLED)
        // Continue response: timeout flagged, device stays up
        stg_fault_to_state = 1'b0;
        host_write(3, 1'b0);
        `CHK(sys_state, eis_pkg::SYS_ACTIVE)
        `CHK(stg_fault_flag, 1'b0)
        for (int i = 0; i < 400 && stg_fault_flag !== 1'b1; i++) tick(1);
        `CHK(stg_fault_flag, 1'b1)
        tick(2);
        `CHK(sys_state, eis_pkg::SYS_ACTIVE)
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end
endmodule : test_enable_input_and_rail_sequencer

`default_nettype wire
